//--- inc/pci_sig_pkg.sv
/*
  Shared constants and types for the bus signal interface: command codes,
  edge counts, reset levels, pin bundles and state encodings.
  Assumes the bench resolves each wire from the output enables and the
  external pull-ups that keep undriven control lines high.
*/
package pci_sig_pkg;

  localparam logic [3:0] CMD_IO_RD  = 4'h2;
  localparam logic [3:0] CMD_IO_WR  = 4'h3;
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_CFG_RD = 4'hA;
  localparam logic [3:0] CMD_CFG_WR = 4'hB;

  // edges without a device select before the master gives up
  localparam int MASTER_ABORT_EDGES = 5;
  // edges a subtractive claim waits for a faster decoder
  localparam int SUB_DECODE_EDGES   = 3;
  localparam int CFG_WORDS_LOG2     = 4;

  localparam logic        LINE_IDLE_RST = 1'h1;
  localparam logic [31:0] AD_RST        = 32'h0000_0000;
  localparam logic [3:0]  CBE_RST       = 4'hF;

  typedef struct packed {
    logic [31:0] ad;
    logic [3:0]  cbe_n;
    logic        frame_n;
    logic        irdy_n;
    logic        trdy_n;
    logic        stop_n;
    logic        devsel_n;
    logic        idsel;
    logic        serr_n;
  } bus_in_t;

  typedef struct packed {
    logic [31:0] ad;
    logic        ad_oe;
    logic [3:0]  cbe_n;
    logic        cbe_oe;
    logic        frame_n;
    logic        frame_oe;
    logic        irdy_n;
    logic        irdy_oe;
    logic        trdy_n;
    logic        trdy_oe;
    logic        stop_n;
    logic        stop_oe;
    logic        devsel_n;
    logic        devsel_oe;
    logic        par;
  } bus_out_t;

  typedef struct packed {
    logic [3:0]  cmd;
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0]  be_n;
  } mst_req_t;

  typedef enum logic [1:0] {
    RES_OK    = 2'b00,
    RES_RETRY = 2'b01,
    RES_ABORT = 2'b10
  } mst_result_t;

  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_ADDR = 2'b01,
    M_DATA = 2'b10,
    M_TURN = 2'b11
  } mst_state_t;

  typedef enum logic [2:0] {
    T_IDLE  = 3'b000,
    T_SUB   = 3'b001,
    T_CLAIM = 3'b010,
    T_DATA  = 3'b011,
    T_WAIT  = 3'b100,
    T_TURN  = 3'b101
  } tgt_state_t;

endpackage : pci_sig_pkg

//--- verilog/cfg_store.sv
/*
  Small word store behind the target, with byte-lane writes and a
  registered read port.
  Assumes write and read addresses come from logic on the same clock.
*/
`timescale 1ns/100ps
module cfg_store #(
  parameter int AW = 4,
  parameter int DW = 32
) (
  // clock and reset
  input  wire logic            clk,
  input  wire logic            rst_n,
  // write port
  input  wire logic            we,
  input  wire logic [DW/8-1:0] be,
  input  wire logic [AW-1:0]   waddr,
  input  wire logic [DW-1:0]   wdata,
  // read port
  input  wire logic [AW-1:0]   raddr,
  output logic      [DW-1:0]   rdata
);

  genvar lane;
  generate
    for (lane = 0; lane < DW/8; lane++) begin : g_lane
      // one narrow array per lane, so every array has a single writer
      logic [7:0] lane_q [0:(1<<AW)-1];

      always_ff @(posedge clk) begin
        if (we && be[lane]) begin
          lane_q[waddr] <= wdata[lane*8 +: 8];
        end
      end

      always_ff @(posedge clk) begin
        if (!rst_n) begin
          rdata[lane*8 +: 8] <= 8'h00;
        end else begin
          rdata[lane*8 +: 8] <= lane_q[raddr];
        end
      end
    end
  endgenerate

endmodule : cfg_store

//--- verilog/pci_bus_signal_interface.sv
/*
  Bus signal interface of the bridge: one-phase initiator, one-phase
  target with configuration, positive and subtractive decode, parity,
  system error intake and hold request with passive release.
  Assumes the bus clock arrives on a pin far slower than clk, and that
  the bench resolves every wire from the enables plus pull-ups.
*/
`timescale 1ns/100ps
module pci_bus_signal_interface
  import pci_sig_pkg::*;
#(
  parameter logic [31:0] WIN_BASE = 32'h000F_0000,
  parameter int          WIN_BITS = 8
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // bus pins
  input  wire logic        bus_clock_in,
  input  wire bus_in_t     bus_in,
  output bus_out_t         bus_out,
  input  wire logic        bus_hold_grant_n,
  output logic             bus_hold_request_n,
  // initiator user side
  input  wire logic        mst_valid,
  input  wire mst_req_t    mst_req,
  output logic             mst_busy,
  output logic             mst_done,
  output mst_result_t      mst_result,
  output logic [31:0]      mst_rdata,
  // system control
  input  wire logic        sub_decode_en,
  input  wire logic        serr_nmi_en,
  input  wire logic        nmi_clear,
  input  wire logic        passive_release,
  output logic             nmi_out
);

  // two-stage synchroniser for every pin input
  typedef struct packed {
    logic    clk_l;
    logic    grant_n;
    bus_in_t b;
  } pin_t;

  pin_t    sync1_reg;
  pin_t    sync2_reg;
  logic    clk_d_reg;
  logic    pci_rise;
  bus_in_t bs;
  logic    grant;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_reg <= '1;
      sync2_reg <= '1;
      clk_d_reg <= 1'h1;
    end else begin
      sync1_reg <= {bus_clock_in, bus_hold_grant_n, bus_in};
      sync2_reg <= sync1_reg;
      clk_d_reg <= sync2_reg.clk_l;
    end
  end

  // bus decisions other than the hold request happen on the detected rising edge
  assign pci_rise = sync2_reg.clk_l & ~clk_d_reg;
  assign bs       = sync2_reg.b;
  assign grant    = ~sync2_reg.grant_n;

  // bus history sampled on each edge
  logic idle_q_reg;
  logic frame_q_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      idle_q_reg  <= 1'h0;
      frame_q_reg <= LINE_IDLE_RST;
    end else if (pci_rise) begin
      idle_q_reg  <= bs.frame_n & bs.irdy_n;
      frame_q_reg <= bs.frame_n;
    end
  end

  // request capture and hold request
  mst_req_t req_reg;
  logic     prel_pend_reg;
  logic     prel_low_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      req_reg <= '0;
    end else if (mst_valid && !mst_busy) begin
      req_reg <= mst_req;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prel_pend_reg <= 1'h0;
      prel_low_reg  <= 1'h0;
    end else begin
      if (passive_release) begin
        prel_pend_reg <= 1'h1;
      end else if (pci_rise && !prel_low_reg) begin
        prel_pend_reg <= 1'h0;
      end
      if (pci_rise) begin
        prel_low_reg <= prel_pend_reg && mst_busy && !prel_low_reg;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus_hold_request_n <= LINE_IDLE_RST;
    end else begin
      bus_hold_request_n <= ~((mst_busy || (mst_valid && !mst_done))
                              && !prel_low_reg);
    end
  end

  // initiator
  mst_state_t m_state;
  logic [2:0] m_cnt_reg;
  logic       m_start;
  logic       m_end;
  logic       m_write;

  assign m_write = req_reg.cmd[0];
  // start only with grant and two idle samples in a row
  assign m_start = (m_state == M_IDLE) && mst_busy && !mst_done && grant
                   && !prel_low_reg && idle_q_reg
                   && bs.frame_n && bs.irdy_n;
  assign m_end   = (m_state == M_DATA) && (!bs.trdy_n || !bs.stop_n
                   || (bs.devsel_n
                   && m_cnt_reg == 3'(MASTER_ABORT_EDGES - 1)));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      m_state    <= M_IDLE;
      m_cnt_reg  <= '0;
      mst_busy   <= 1'h0;
      mst_done   <= 1'h0;
      mst_result <= RES_OK;
      mst_rdata  <= AD_RST;
    end else begin
      mst_done <= 1'h0;
      if (mst_valid && !mst_busy) begin
        mst_busy <= 1'h1;
      end
      if (pci_rise) begin
        case (m_state)
          M_IDLE: begin
            if (m_start) begin
              m_state <= M_ADDR;
            end
          end
          M_ADDR: begin
            m_state   <= M_DATA;
            m_cnt_reg <= '0;
          end
          M_DATA: begin
            if (m_end) begin
              m_state  <= M_TURN;
              mst_done <= 1'h1;
              mst_busy <= 1'h0;
              if (!bs.trdy_n) begin
                mst_result <= RES_OK;
                mst_rdata  <= bs.ad;
              end else if (!bs.stop_n) begin
                mst_result <= RES_RETRY;
              end else begin
                mst_result <= RES_ABORT;
              end
            end else if (bs.devsel_n) begin
              m_cnt_reg <= m_cnt_reg + 3'h1;
            end
          end
          M_TURN: m_state <= M_IDLE;
          default: m_state <= M_IDLE;
        endcase
      end
    end
  end

  // frame and initiator ready; frame goes high for the single last phase
  logic frame_n_reg, frame_oe_reg, irdy_n_reg, irdy_oe_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      frame_n_reg  <= LINE_IDLE_RST;
      frame_oe_reg <= 1'h0;
      irdy_n_reg   <= LINE_IDLE_RST;
      irdy_oe_reg  <= 1'h0;
    end else if (pci_rise) begin
      if (m_start) begin
        frame_n_reg  <= 1'h0;
        frame_oe_reg <= 1'h1;
      end else if (m_state == M_ADDR) begin
        frame_n_reg <= 1'h1;
        irdy_n_reg  <= 1'h0;
        irdy_oe_reg <= 1'h1;
      end else if (m_end) begin
        frame_oe_reg <= 1'h0;
        irdy_n_reg   <= 1'h1;
      end else if (m_state == M_TURN) begin
        irdy_oe_reg <= 1'h0;
      end
    end
  end

  // target
  tgt_state_t t_state;
  logic [3:0] t_cmd_reg;
  logic [2:0] t_cnt_reg;
  logic       t_new;
  logic       t_cfg_hit;
  logic       t_pos_hit;
  logic       t_sub_ok;
  logic       t_read;
  logic       t_last;

  // a cycle of our own initiator is never decoded here
  assign t_new     = pci_rise && !bs.frame_n && frame_q_reg
                     && (m_state == M_IDLE);
  assign t_cfg_hit = bs.idsel && (bs.cbe_n[3:1] == CMD_CFG_RD[3:1]);
  assign t_pos_hit = (bs.cbe_n[3:1] == CMD_MEM_RD[3:1]) &&
                     (bs.ad[31:WIN_BITS] == WIN_BASE[31:WIN_BITS]);
  assign t_sub_ok  = sub_decode_en && ((bs.cbe_n[3:1] == CMD_MEM_RD[3:1])
                     || (bs.cbe_n[3:1] == CMD_IO_RD[3:1]));
  assign t_read    = ~t_cmd_reg[0];
  assign t_last    = (t_state == T_DATA) && pci_rise && !bs.irdy_n;

  logic [CFG_WORDS_LOG2-1:0] t_addr_reg;
  logic                      mem_we;
  logic [31:0]               mem_rdata;

  assign mem_we = t_last && !t_read;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      t_state    <= T_IDLE;
      t_cmd_reg  <= '0;
      t_cnt_reg  <= '0;
      t_addr_reg <= '0;
    end else if (pci_rise) begin
      case (t_state)
        T_IDLE: begin
          if (t_new) begin
            t_cmd_reg  <= bs.cbe_n;
            t_addr_reg <= bs.ad[CFG_WORDS_LOG2+1:2];
            t_cnt_reg  <= '0;
            if (t_cfg_hit || t_pos_hit) begin
              t_state <= T_CLAIM;
            end else if (t_sub_ok) begin
              t_state <= T_SUB;
            end
          end
        end
        T_SUB: begin
          if (!bs.devsel_n) begin
            t_state <= T_IDLE;
          end else if (t_cnt_reg == 3'(SUB_DECODE_EDGES - 1)) begin
            t_state <= T_CLAIM;
          end else begin
            t_cnt_reg <= t_cnt_reg + 3'h1;
          end
        end
        T_CLAIM: t_state <= T_DATA;
        T_DATA: begin
          if (!bs.irdy_n) begin
            t_state <= bs.frame_n ? T_TURN : T_WAIT;
          end
        end
        T_WAIT: begin
          // stop stays up until the master has ended the frame
          if (bs.frame_n) begin
            t_state <= T_TURN;
          end
        end
        T_TURN: t_state <= T_IDLE;
        default: t_state <= T_IDLE;
      endcase
    end
  end

  logic devsel_n_reg, trdy_n_reg, stop_n_reg, tgt_oe_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      devsel_n_reg <= LINE_IDLE_RST;
      trdy_n_reg   <= LINE_IDLE_RST;
      stop_n_reg   <= LINE_IDLE_RST;
      tgt_oe_reg   <= 1'h0;
    end else if (pci_rise) begin
      case (t_state)
        T_CLAIM: begin
          devsel_n_reg <= 1'h0;
          tgt_oe_reg   <= 1'h1;
          // read data is in the store register by now
          trdy_n_reg   <= 1'h0;
          stop_n_reg   <= bs.frame_n;
        end
        T_DATA: begin
          if (!bs.irdy_n) begin
            trdy_n_reg <= 1'h1;
            if (bs.frame_n) begin
              devsel_n_reg <= 1'h1;
              stop_n_reg   <= 1'h1;
            end
          end
        end
        T_WAIT: begin
          if (bs.frame_n) begin
            devsel_n_reg <= 1'h1;
            stop_n_reg   <= 1'h1;
          end
        end
        T_TURN: tgt_oe_reg <= 1'h0;
        default: tgt_oe_reg <= tgt_oe_reg;
      endcase
    end
  end

  // address/data lines, shared by both roles; command lines, driven by the initiator only
  logic [31:0] ad_reg;
  logic        ad_oe_reg;
  logic [3:0]  cbe_reg;
  logic        cbe_oe_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ad_reg     <= AD_RST;
      ad_oe_reg  <= 1'h0;
      cbe_reg    <= CBE_RST;
      cbe_oe_reg <= 1'h0;
    end else if (pci_rise) begin
      if (m_start) begin
        ad_reg     <= req_reg.addr;
        ad_oe_reg  <= 1'h1;
        cbe_reg    <= req_reg.cmd;
        cbe_oe_reg <= 1'h1;
      end else if (m_state == M_ADDR) begin
        ad_reg    <= req_reg.data;
        ad_oe_reg <= m_write;
        cbe_reg   <= req_reg.be_n;
      end else if (m_end) begin
        ad_oe_reg  <= 1'h0;
        cbe_oe_reg <= 1'h0;
      end else if (t_state == T_CLAIM && t_read) begin
        ad_reg    <= mem_rdata;
        ad_oe_reg <= 1'h1;
      end else if (t_last) begin
        ad_oe_reg <= 1'h0;
      end
    end
  end

  // parity covers the lines as they stood on the previous edge
  logic par_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      par_reg <= 1'h0;
    end else if (pci_rise) begin
      par_reg <= ^{bs.ad, bs.cbe_n};
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      nmi_out <= 1'h0;
    end else if (pci_rise && !bs.serr_n && serr_nmi_en) begin
      nmi_out <= 1'h1;
    end else if (nmi_clear) begin
      nmi_out <= 1'h0;
    end
  end

  cfg_store #(
    .AW (CFG_WORDS_LOG2),
    .DW (32)
  ) u_store (
    .clk   (clk),
    .rst_n (rst_n),
    .we    (mem_we),
    .be    (~bs.cbe_n),
    .waddr (t_addr_reg),
    .wdata (bs.ad),
    .raddr (t_addr_reg),
    .rdata (mem_rdata)
  );

  assign bus_out = '{ad: ad_reg, ad_oe: ad_oe_reg, cbe_n: cbe_reg,
                     cbe_oe: cbe_oe_reg, frame_n: frame_n_reg,
                     frame_oe: frame_oe_reg, irdy_n: irdy_n_reg,
                     irdy_oe: irdy_oe_reg, trdy_n: trdy_n_reg,
                     trdy_oe: tgt_oe_reg, stop_n: stop_n_reg,
                     stop_oe: tgt_oe_reg, devsel_n: devsel_n_reg,
                     devsel_oe: tgt_oe_reg, par: par_reg};

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_prel_high;
    pci_rise && prel_low_reg;
  endsequence

  chk_frame_float: assert property ($fell(frame_oe_reg) |->
    $past(frame_n_reg)) else $error("frame floated while low");
  chk_devsel_float: assert property ($fell(tgt_oe_reg) |->
    $past(devsel_n_reg && trdy_n_reg && stop_n_reg))
    else $error("target line floated while low");
  chk_start_gap: assert property ($rose(frame_oe_reg) |->
    $past(idle_q_reg && grant)) else $error("start without gap");
  chk_addr_phase: assert property ($rose(frame_oe_reg) |->
    !frame_n_reg && ad_oe_reg && ad_reg == req_reg.addr
    && cbe_reg == req_reg.cmd) else $error("bad address phase");
  chk_last_phase: assert property (m_state == M_DATA |->
    frame_n_reg && !irdy_n_reg && frame_oe_reg)
    else $error("data phase not final");
  chk_stop_ends: assert property (pci_rise && m_state == M_DATA
    && !bs.stop_n |=> m_state == M_TURN && mst_done)
    else $error("stop ignored");
  chk_cfg_claim: assert property (pci_rise && t_state == T_IDLE && t_new
    && !bs.idsel && !t_pos_hit |=> t_state != T_CLAIM)
    else $error("config claimed without select");
  chk_even_par: assert property (pci_rise |=>
    ^{par_reg, $past(bs.ad), $past(bs.cbe_n)} == 1'h0)
    else $error("parity not even");
  chk_nmi_raise: assert property (pci_rise && !bs.serr_n && serr_nmi_en
    |=> nmi_out ##1 (nmi_out || nmi_clear))
    else $error("nmi missed");
  chk_prel_pulse: assert property (s_prel_high |=> !prel_low_reg)
    else $error("release longer than one clock");
  chk_trdy_ready: assert property (!trdy_n_reg && tgt_oe_reg |->
    t_state == T_DATA) else $error("ready outside data");

endmodule : pci_bus_signal_interface

//--- verification/bus_far_side.sv
/*
  Far side of the bus: arbiter, a target for the device's initiator and
  an initiator for the device's target.
  Assumes the bench resolves each wire and floats released lines.
*/
`timescale 1ns/100ps
module bus_far_side
  import pci_sig_pkg::*;
(
  // bus clock, reset, resolved wires
  input  wire logic        bclk,
  input  wire logic        rst_n,
  input  wire bus_in_t     w,
  // arbitration
  input  wire logic        req_n,
  output logic             grant_n,
  // own drives
  output bus_out_t         drv,
  output logic             idsel,
  // target: mode 0 ready, 1 stop, 2 silent
  input  wire logic [1:0]  tmode,
  input  wire logic [31:0] trdata,
  output logic [31:0]      twdata,
  // initiator
  input  wire logic        go,
  input  wire logic        isel,
  input  wire mst_req_t    ireq,
  output logic             idone,
  output logic [1:0]       ires,
  output logic [31:0]      irdata
);
  bus_out_t d;
  int       ts;
  int       is;
  int       n;
  logic     trd, ird, fp;

  initial begin
    drv = '0;
    grant_n = 1'b1;
    idsel = 1'b0;
    idone = 1'b0;
  end

  // changes land 6 ns after the edge, well after the device samples
  always @(posedge bclk) begin
    grant_n <= #6 req_n;
    if (!rst_n) begin
      d = '0;
      ts = 0;
      is = 0;
    end else begin
      case (ts)
        0: if (!w.frame_n && fp && is == 0 && w.ad[31:28] == 4'h4
               && tmode != 2'h2) begin
          trd = !w.cbe_n[0];
          ts = 1;
        end
        1: begin
          {d.devsel_oe, d.devsel_n, d.trdy_oe} = 3'h7;
          {d.trdy_n, d.stop_oe, d.stop_n} = 3'h7;
          ts = 2;
        end
        2: begin
          d.devsel_n = 1'b0;
          if (tmode == 2'h1) d.stop_n = 1'b0;
          else {d.trdy_n, d.ad_oe, d.ad} = {1'b0, trd, trdata};
          ts = 3;
        end
        3: if (!w.irdy_n && !(w.trdy_n && w.stop_n)) begin
          twdata <= w.ad;
          {d.devsel_n, d.trdy_n, d.stop_n, d.ad_oe} = 4'hE;
          ts = 4;
        end
        default: begin
          {d.devsel_oe, d.trdy_oe, d.stop_oe} = 3'h0;
          ts = 0;
        end
      endcase
      case (is)
        0: if (go) begin
          {d.frame_oe, d.frame_n, d.irdy_oe, d.irdy_n} = 4'hB;
          {d.ad_oe, d.ad, d.cbe_oe} = {1'b1, ireq.addr, 1'b1};
          d.cbe_n = ireq.cmd;
          ird = !ireq.cmd[0];
          n = 0;
          is = 1;
        end
        1: begin
          {d.frame_n, d.irdy_n, d.cbe_n} = {2'h2, ireq.be_n};
          {d.ad_oe, d.ad} = {!ird, ireq.data};
          is = 2;
        end
        2: begin
          n++;
          // eight edges covers a late subtractive claim
          if (!w.trdy_n || !w.stop_n || n == 8) begin
            ires <= !w.trdy_n ? 2'h0 : !w.stop_n ? 2'h1 : 2'h2;
            irdata <= w.ad;
            idone <= #6 1'b1;
            {d.irdy_n, d.frame_oe, d.ad_oe, d.cbe_oe} = 4'h8;
            is = 3;
          end
        end
        default: begin
          d.irdy_oe = 1'b0;
          idone <= #6 1'b0;
          is = 0;
        end
      endcase
    end
    fp = w.frame_n;
    idsel <= #6 (is == 1) && isel;
    drv <= #6 d;
  end
endmodule : bus_far_side

//--- verification/pci_bus_signal_interface_tb.sv
/*
  Self-checking bench: resolves the wires, drives the user side, checks
  results against a queue of expected notes.
  Assumes the far-side model bus_far_side.
*/
`timescale 1ns/100ps
module pci_bus_signal_interface_tb
  import pci_sig_pkg::*;
;
  logic        clk, rst_n, bclk, req_n, grant_n, mst_valid, mst_busy;
  logic        mst_done, sub_en, nmi_en, nmi_clear, prel, nmi_out;
  logic        serr_n, psel, go, isel, pd, ep;
  wire bus_in_t bi;
  bus_out_t    o, p;
  mst_req_t    mst_req, ireq;
  mst_result_t mst_result;
  logic [1:0]  tmode, pres;
  logic [31:0] mst_rdata, trdata, twdata, prd, fl, d1, d2;
  logic [35:0] expq[$];
  int          num_errors, total_checks, seed, hcnt, pc;

  function automatic logic pu(logic a, logic av, logic b, logic bv);
    return a ? av : b ? bv : 1'b1;
  endfunction : pu

  // control lines float high on pull-ups, data lines float to noise
  assign bi.ad = o.ad_oe ? o.ad : p.ad_oe ? p.ad : fl;
  assign bi.cbe_n = o.cbe_oe ? o.cbe_n : p.cbe_oe ? p.cbe_n : fl[3:0];
  assign bi.frame_n = pu(o.frame_oe, o.frame_n, p.frame_oe, p.frame_n);
  assign bi.irdy_n = pu(o.irdy_oe, o.irdy_n, p.irdy_oe, p.irdy_n);
  assign bi.trdy_n = pu(o.trdy_oe, o.trdy_n, p.trdy_oe, p.trdy_n);
  assign bi.stop_n = pu(o.stop_oe, o.stop_n, p.stop_oe, p.stop_n);
  assign bi.devsel_n = pu(o.devsel_oe, o.devsel_n, p.devsel_oe, p.devsel_n);
  assign bi.idsel = psel;
  assign bi.serr_n = serr_n;

  pci_bus_signal_interface u_pci_bus_signal_interface (
    .clk(clk), .rst_n(rst_n), .bus_clock_in(bclk), .bus_in(bi),
    .bus_out(o), .bus_hold_grant_n(grant_n), .bus_hold_request_n(req_n),
    .mst_valid(mst_valid), .mst_req(mst_req), .mst_busy(mst_busy),
    .mst_done(mst_done), .mst_result(mst_result), .mst_rdata(mst_rdata),
    .sub_decode_en(sub_en), .serr_nmi_en(nmi_en), .nmi_clear(nmi_clear),
    .passive_release(prel), .nmi_out(nmi_out));

  bus_far_side u_bus_far_side (
    .bclk(bclk), .rst_n(rst_n), .w(bi), .req_n(req_n), .grant_n(grant_n),
    .drv(p), .idsel(psel), .tmode(tmode), .trdata(trdata),
    .twdata(twdata), .go(go), .isel(isel), .ireq(ireq), .idone(pd),
    .ires(pres), .irdata(prd));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    bclk = 1'b0;
    forever #15 bclk = ~bclk;
  end

  task automatic chk(input string nm, input logic [35:0] e,
                     input logic [35:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // note layout: source, data matters, result code, data
  task automatic take(input logic s, input logic [1:0] r,
                      input logic [31:0] d);
    logic [35:0] e;
    e = expq.size() != 0 ? expq.pop_front() : 36'hF_FFFF_FFFF;
    chk("result", e, {s, e[34], r, e[34] ? d : e[31:0]});
  endtask : take

  // sampled mid-cycle, while the one-cycle done pulse stands
  always @(negedge clk)
    if (mst_done === 1'b1) take(1'b0, mst_result, mst_rdata);
  always @(posedge pd) take(1'b1, pres, prd);

  always @(posedge clk)
    if (mst_valid === 1'b1) hcnt = 0;
    else if (mst_busy === 1'b1 && mst_done !== 1'b1 && req_n === 1'b1) hcnt++;

  always @(posedge bclk) begin
    if (pc == 3) chk("parity", {35'h0, ep}, {35'h0, o.par});
    ep = ^{bi.ad, bi.cbe_n};
    pc = !rst_n ? 0 : pc < 3 ? pc + 1 : 3;
    fl <= #6 $random(seed);
  end

  task automatic mst(input logic [3:0] c, input logic [31:0] a,
                     input logic [31:0] d, input logic pr,
                     input logic [35:0] e);
    expq.push_back(e);
    @(negedge clk);
    mst_valid = 1'b1;
    mst_req = {c, a, d, 4'h0};
    @(negedge clk);
    mst_valid = 1'b0;
    if (pr) begin
      @(negedge clk);
      prel = 1'b1;
      @(negedge clk);
      prel = 1'b0;
    end
    for (int i = 0; i < 3000 && mst_busy !== 1'b0; i++) @(negedge clk);
    repeat (4) @(posedge bclk);
  endtask : mst

  task automatic ini(input logic [3:0] c, input logic [31:0] a,
                     input logic [31:0] d, input logic [3:0] b,
                     input logic s, input logic [35:0] e);
    expq.push_back(e);
    @(posedge bclk);
    #6;
    ireq = {c, a, d, b};
    isel = s;
    go = 1'b1;
    @(posedge bclk);
    #6;
    go = 1'b0;
    for (int i = 0; i < 20 && pd !== 1'b1; i++) @(posedge bclk);
    repeat (4) @(posedge bclk);
  endtask : ini

  task automatic serr_pulse;
    @(posedge bclk);
    #6;
    serr_n = 1'b0;
    @(posedge bclk);
    #6;
    serr_n = 1'b1;
    repeat (2) @(posedge bclk);
    @(negedge clk);
  endtask : serr_pulse

  task automatic tally_and_finish;
    if (expq.size() != 0) num_errors++;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (40000) @(posedge clk);
    chk("watchdog", 36'h0, 36'h1);
    tally_and_finish();
  end

  initial begin
    {seed, num_errors, total_checks, hcnt, pc} = {32'h1CB3, 128'h0};
    {rst_n, mst_valid, sub_en, nmi_en, nmi_clear, prel} = 6'h04;
    {serr_n, go, isel, tmode, trdata, fl} = {3'h4, 66'h0};
    {mst_req, ireq} = '0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(posedge bclk);
    d1 = $random(seed);
    mst(CMD_MEM_WR, 32'h4000_0010, d1, 1'b1, 36'h0);
    chk("far write", {4'h0, d1}, {4'h0, twdata});
    chk("release", 36'h1, {35'h0, hcnt >= 7 && hcnt <= 8});
    // ready, stop and silence give ok, retry and abort
    for (int m = 0; m < 3; m++) begin
      tmode = m[1:0];
      trdata = $random(seed);
      mst(CMD_MEM_RD, 32'h4000_0020, 32'h0, 1'b0,
          {1'b0, m == 0, m[1:0], trdata});
      chk("hold", 36'h0, 36'(hcnt));
    end
    tmode = 2'h0;
    d1 = $random(seed);
    d2 = $random(seed);
    ini(CMD_MEM_WR, 32'h000F_0010, d1, 4'h0, 1'b0, 36'h8_0000_0000);
    ini(CMD_MEM_WR, 32'h000F_0010, d2, 4'hE, 1'b0, 36'h8_0000_0000);
    ini(CMD_MEM_RD, 32'h000F_0010, 32'h0, 4'h0, 1'b0,
        {4'hC, d1[31:8], d2[7:0]});
    ini(CMD_CFG_WR, 32'h0000_0024, d2, 4'h0, 1'b1, 36'h8_0000_0000);
    ini(CMD_CFG_RD, 32'h0000_0024, 32'h0, 4'h0, 1'b0, 36'hA_0000_0000);
    ini(CMD_CFG_RD, 32'h0000_0024, 32'h0, 4'h0, 1'b1, {4'hC, d2});
    ini(CMD_IO_RD, 32'h0000_1010, 32'h0, 4'h0, 1'b0,
        36'hA_0000_0000);
    @(negedge clk);
    sub_en = 1'b1;
    // word four was written above, so the claimed read returns known data
    ini(CMD_IO_RD, 32'h0000_1010, 32'h0, 4'h0, 1'b0,
        {4'hC, d1[31:8], d2[7:0]});
    serr_pulse();
    chk("nmi set", 36'h1, {35'h0, nmi_out});
    nmi_clear = 1'b1;
    @(negedge clk);
    nmi_clear = 1'b0;
    nmi_en = 1'b0;
    @(negedge clk);
    chk("nmi clear", 36'h0, {35'h0, nmi_out});
    serr_pulse();
    chk("nmi masked", 36'h0, {35'h0, nmi_out});
    tally_and_finish();
  end
endmodule : pci_bus_signal_interface_tb
